// [hw/flags_pkg.sv]
package flags_pkg;

    // Register map; address bits above the decode width are not compared
    localparam int DECODE_BITS = 24;
    localparam logic [31:0] CORE_CONTROL_OFFSET = 32'hffff_e012;
    localparam logic [31:0] FLAGS_OFFSET = 32'hffff_e010;
    localparam logic [7:0] CORE_CONTROL_RESET = 8'hff;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int SHARE_LSB = 0;
    localparam int SHARE_MSB = 1;
    localparam int CTRL_RSVD_LSB = 2;
    localparam int CTRL_RSVD_MSB = 7;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;

    // Short addresses sign-extend into this many address bits
    localparam int ADDR_W = 24;
    localparam int SHORT_ADDR_W = 16;

    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_QUAD
    } size_e;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ADD,
        OP_SUB,
        OP_LOGIC,
        OP_SHIFT,
        OP_BITTEST,
        OP_LOAD,
        OP_POP
    } op_kind_e;

    // Flag byte, carry in the top bit
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic b;
        logic user_status_bit;
        logic chain_enable_bit;
        logic global_int_enable;
    } flags_s;

    typedef struct packed {
        logic valid;
        op_kind_e kind;
        size_e size;
        logic reg_dst;
        logic [31:0] dst_val;
        logic [31:0] src_val;
        logic [31:0] result;
        logic shift_carry;
        logic shift_prev_msb;
        logic blank_dst;
        logic blank_src;
        logic ext_signed;
    } exec_op_s;

    typedef struct packed {
        logic valid;
        flags_s data;
    } flags_load_s;

    typedef struct packed {
        logic valid;
        logic [3:0] jump_condition_field;
    } jump_req_s;

    function automatic logic msb_of(logic [31:0] v, size_e sz);
        unique case (sz)
            SZ_BYTE: return v[7];
            SZ_WORD: return v[15];
            default: return v[31];
        endcase
    endfunction : msb_of

    function automatic logic [31:0] extend(logic [31:0] v, size_e sz,
                                           logic sgn);
        unique case (sz)
            SZ_BYTE: return sgn ? {{24{v[7]}}, v[7:0]}
                                : {24'h00_0000, v[7:0]};
            SZ_WORD: return sgn ? {{16{v[15]}}, v[15:0]}
                                : {16'h0000, v[15:0]};
            default: return v;
        endcase
    endfunction : extend

    function automatic logic is_zero(logic [31:0] v, size_e sz);
        return extend(v, sz, 1'b0) == 32'h0000_0000;
    endfunction : is_zero

    function automatic logic cond_true(logic [3:0] code, flags_s f);
        logic low;
        low = 1'b0;
        unique case (code[2:0])
            3'h0: low = f.b;
            3'h1: low = f.s ^ f.v;
            3'h2: low = f.z | (f.s ^ f.v);
            3'h3: low = f.c | f.z;
            3'h4: low = f.v;
            3'h5: low = f.s;
            3'h6: low = f.z;
            3'h7: low = f.c;
        endcase
        return code[3] ? ~low : low;
    endfunction : cond_true

    function automatic logic [ADDR_W-1:0] sext_short(
            logic [SHORT_ADDR_W-1:0] a);
        return {{(ADDR_W - SHORT_ADDR_W){a[SHORT_ADDR_W-1]}}, a};
    endfunction : sext_short

endpackage : flags_pkg

// [hw/dma_share_limiter.sv]
`timescale 1ns/1ps

module dma_share_limiter #(
    parameter int SEL_W = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Share setting
    input wire logic [SEL_W-1:0] dma_share_select,
    // Activity
    input wire logic cpu_op_done,
    input wire logic dma_req,
    input wire logic dma_done,
    // Decisions
    output logic dma_grant_reg,
    output logic cpu_hold_reg
);
    import flags_pkg::*;

    // Refuse widths the counter compare cannot serve
    if (SEL_W < 1 || SEL_W > 8) begin : g_bad_width
        $error("dma_share_limiter: SEL_W out of range");
    end

    logic [SEL_W-1:0] op_count_reg;
    logic full_share;
    logic ratio_met;

    assign full_share = dma_share_select == '0;
    assign ratio_met = full_share || op_count_reg >= dma_share_select;

    // Count finished CPU operations, restart once the DMA slot is used
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            op_count_reg <= '0;
        end else if (dma_done) begin
            op_count_reg <= '0;
        end else if (cpu_op_done && !ratio_met) begin
            op_count_reg <= op_count_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dma_grant_reg <= 1'b0;
        end else begin
            dma_grant_reg <= dma_req && !dma_done && ratio_met;
        end
    end

    // At full share the CPU stands still while DMA wants the bus
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_hold_reg <= 1'b0;
        end else begin
            cpu_hold_reg <= dma_req && full_share;
        end
    end

    a_full_share_grant: assert property (@(posedge sys_clk) disable iff (!rstn)
        (dma_req && !dma_done && dma_share_select == '0)
        |=> (dma_grant_reg && cpu_hold_reg))
        else $error("full share did not grant DMA");

    a_ratio_not_met: assert property (@(posedge sys_clk) disable iff (!rstn)
        (dma_share_select != '0 && op_count_reg < dma_share_select)
        |=> !dma_grant_reg)
        else $error("DMA granted before CPU ops were counted");

endmodule : dma_share_limiter

// [hw/status_flags_cond_eval.sv]
`timescale 1ns/1ps

module status_flags_cond_eval (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Execution unit results
    input wire flags_pkg::exec_op_s exec_op,
    input wire flags_pkg::flags_load_s flags_load,
    input wire logic exc_take,
    // Interrupt gate
    input wire logic irq_pending,
    // Conditional jump
    input wire flags_pkg::jump_req_s jump_req,
    // Short address expansion
    input wire logic short_addr_valid,
    input wire logic [15:0] short_addr,
    // Control register access
    input wire logic [31:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    // DMA arbitration
    input wire logic cpu_op_done,
    input wire logic dma_req,
    input wire logic dma_done,
    // Outputs
    output flags_pkg::flags_s flags_reg,
    output logic jump_done_reg,
    output logic jump_taken_reg,
    output logic irq_allowed_reg,
    output logic [23:0] full_addr_reg,
    output logic [7:0] reg_rdata_reg,
    output logic dma_grant_reg,
    output logic cpu_hold_reg
);
    import flags_pkg::*;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    flags_s flags_next;
    logic [1:0] dma_share_select;
    size_e eff_size;
    logic dst_msb;
    logic src_msb;
    logic res_msb;
    logic res_zero;
    logic blank_tested;
    logic blank_hit;
    logic hit_ctrl;
    logic hit_flags;

    // Register targets always judge the full word
    assign eff_size = exec_op.reg_dst ? SZ_QUAD : exec_op.size;
    assign dst_msb = msb_of(exec_op.dst_val, eff_size);
    assign src_msb = msb_of(exec_op.src_val, eff_size);
    assign res_msb = msb_of(exec_op.result, eff_size);
    assign res_zero = is_zero(exec_op.result, eff_size);

    // Operands are checked after the extension the instruction asks for
    assign blank_tested = exec_op.blank_dst || exec_op.blank_src;
    assign blank_hit =
        (exec_op.blank_dst &&
         extend(exec_op.dst_val, eff_size, exec_op.ext_signed)
             == 32'h0000_0000) ||
        (exec_op.blank_src &&
         extend(exec_op.src_val, eff_size, exec_op.ext_signed)
             == 32'h0000_0000);

    // Upper address byte is not compared
    assign hit_ctrl = reg_addr[DECODE_BITS-1:0]
                   == CORE_CONTROL_OFFSET[DECODE_BITS-1:0];
    assign hit_flags = reg_addr[DECODE_BITS-1:0]
                    == FLAGS_OFFSET[DECODE_BITS-1:0];

    always_comb begin
        flags_next = flags_reg;
        if (exc_take) begin
            // Pushed byte is flags_reg this cycle; the chain bit moves after
            flags_next.chain_enable_bit = flags_reg.global_int_enable;
        end else if (flags_load.valid) begin
            flags_next = flags_load.data;
        end else if (reg_wr && hit_flags) begin
            flags_next = flags_s'(reg_wdata);
        end else if (exec_op.valid) begin
            unique case (exec_op.kind)
                OP_ADD: begin
                    flags_next.c = (dst_msb & src_msb) |
                                   ((dst_msb | src_msb) & ~res_msb);
                    flags_next.z = res_zero;
                    flags_next.s = res_msb;
                    flags_next.v = (dst_msb == src_msb) &&
                                   (res_msb != dst_msb);
                    if (blank_tested) begin
                        flags_next.b = blank_hit;
                    end
                end
                OP_SUB: begin
                    flags_next.c = (~dst_msb & src_msb) |
                                   ((~dst_msb | src_msb) & res_msb);
                    flags_next.z = res_zero;
                    flags_next.s = res_msb;
                    flags_next.v = (dst_msb != src_msb) &&
                                   (res_msb == src_msb);
                    if (blank_tested) begin
                        flags_next.b = blank_hit;
                    end
                end
                OP_LOGIC: begin
                    flags_next.z = res_zero;
                    flags_next.s = res_msb;
                    flags_next.v = 1'b0;
                    if (blank_tested) begin
                        flags_next.b = blank_hit;
                    end
                end
                OP_SHIFT: begin
                    flags_next.c = exec_op.shift_carry;
                    flags_next.z = res_zero;
                    flags_next.s = res_msb;
                    flags_next.v = exec_op.shift_prev_msb ^ res_msb;
                end
                OP_BITTEST: begin
                    flags_next.z = res_zero;
                end
                OP_LOAD, OP_POP: begin
                    if (blank_tested) begin
                        flags_next.b = blank_hit;
                    end
                end
                OP_NONE: begin
                    flags_next = flags_reg;
                end
                default: begin
                    flags_next = flags_reg;
                end
            endcase
        end
    end

    // User and chain bits start clear; arithmetic never reaches them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= flags_s'(FLAGS_RESET);
        end else begin
            flags_reg <= flags_next;
        end
    end

    // The condition test looks only at the five arithmetic flags
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            jump_done_reg <= 1'b0;
            jump_taken_reg <= 1'b0;
        end else begin
            jump_done_reg <= jump_req.valid;
            jump_taken_reg <= jump_req.valid &&
                cond_true(jump_req.jump_condition_field, flags_reg);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_allowed_reg <= 1'b0;
        end else begin
            irq_allowed_reg <= irq_pending &&
                               flags_reg.global_int_enable;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            full_addr_reg <= 24'h00_0000;
        end else if (short_addr_valid) begin
            full_addr_reg <= sext_short(short_addr);
        end
    end

    // Only the share field is writable; reserved bits ignore writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dma_share_select <= CORE_CONTROL_RESET[SHARE_MSB:SHARE_LSB];
        end else if (reg_wr && hit_ctrl) begin
            dma_share_select <= reg_wdata[SHARE_MSB:SHARE_LSB];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            if (hit_ctrl) begin
                reg_rdata_reg <= {
                    CORE_CONTROL_RESET[CTRL_RSVD_MSB:CTRL_RSVD_LSB],
                    dma_share_select};
            end else if (hit_flags) begin
                reg_rdata_reg <= flags_reg;
            end else begin
                reg_rdata_reg <= UNMAPPED_READ;
            end
        end
    end

    dma_share_limiter #(
        .SEL_W(2)
    ) u_share (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .dma_share_select(dma_share_select),
        .cpu_op_done(cpu_op_done),
        .dma_req(dma_req),
        .dma_done(dma_done),
        .dma_grant_reg(dma_grant_reg),
        .cpu_hold_reg(cpu_hold_reg)
    );

    wire op_only;
    assign op_only = exec_op.valid && !exc_take && !flags_load.valid &&
                     !(reg_wr && hit_flags);

    a_add_overflow: assert property (
        (op_only && exec_op.kind == OP_ADD && exec_op.reg_dst)
        |=> flags_reg.v == ($past(exec_op.dst_val[31]) ==
                            $past(exec_op.src_val[31]) &&
                            $past(exec_op.result[31]) !=
                            $past(exec_op.dst_val[31])))
        else $error("add overflow flag wrong");

    a_logic_clears_v: assert property (
        (op_only && exec_op.kind == OP_LOGIC) |=> !flags_reg.v)
        else $error("overflow not cleared after logical op");

    a_zero_quad: assert property (
        (op_only && exec_op.kind == OP_SUB && exec_op.reg_dst)
        |=> flags_reg.z == ($past(exec_op.result) == 32'h0000_0000))
        else $error("zero flag wrong for register result");

    a_user_bit_kept: assert property (
        op_only |=> $stable(flags_reg.user_status_bit) &&
                    $stable(flags_reg.chain_enable_bit))
        else $error("user or chain bit changed by arithmetic");

    a_chain_copy: assert property (
        exc_take |=> flags_reg.chain_enable_bit ==
                     $past(flags_reg.global_int_enable))
        else $error("chain bit did not take prior global enable");

    a_irq_gate: assert property (
        !flags_reg.global_int_enable |=> !irq_allowed_reg)
        else $error("interrupt passed with global enable clear");

    a_jump_zero: assert property (
        (jump_req.valid && jump_req.jump_condition_field == 4'h6)
        |=> jump_done_reg && jump_taken_reg == $past(flags_reg.z))
        else $error("zero condition evaluated wrongly");

    a_jump_invert: assert property (
        (jump_req.valid && jump_req.jump_condition_field == 4'hf)
        |=> jump_taken_reg == !$past(flags_reg.c))
        else $error("no-carry condition evaluated wrongly");

    a_ctrl_reserved: assert property (
        (reg_rd && hit_ctrl) |=> reg_rdata_reg[7:2] == 6'h3f)
        else $error("reserved control bits did not read as ones");

    a_short_sign: assert property (
        short_addr_valid |=> full_addr_reg[23:16] ==
                             {8{$past(short_addr[15])}})
        else $error("short address not sign-extended");

    a_flag_restore: assert property (
        (flags_load.valid && !exc_take)
        |=> flags_reg == $past(flags_load.data))
        else $error("flags byte not restored from load");

    a_load_blank_only: assert property (
        (op_only && exec_op.kind inside {OP_LOAD, OP_POP})
        |=> flags_reg[7:4] == $past(flags_reg[7:4]))
        else $error("load or pop changed a flag other than blank");

endmodule : status_flags_cond_eval

// [sim/dma_partner.sv]
`timescale 1ns/1ps

module dma_partner (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Bench control
    input wire logic start,
    input wire logic slow,
    // Arbitration
    input wire logic dma_grant_reg,
    output logic dma_req,
    output logic dma_done
);
    initial begin
        dma_req = 1'b0;
        dma_done = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (rstn && start && !dma_req) begin
                #1;
                dma_req = 1'b1;
            end else if (dma_req && dma_grant_reg && !dma_done) begin
                // A slow controller keeps the bus for extra cycles
                repeat (slow ? 3 : 0) @(posedge sys_clk);
                #1;
                dma_done = 1'b1;
                @(posedge sys_clk);
                #1;
                dma_done = 1'b0;
                dma_req = 1'b0;
            end
        end
    end
endmodule : dma_partner

// [sim/tb_status_flags_cond_eval.sv]
`timescale 1ns/1ps

module tb_status_flags_cond_eval;
    import flags_pkg::*;

`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("ERROR %0t: got %h expected %h", $time, got, exp); \
        end \
    end

    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    exec_op_s exec_op = '0;
    flags_load_s flags_load = '0;
    jump_req_s jump_req = '0;
    logic exc_take = 1'b0;
    logic irq_pending = 1'b0;
    logic short_addr_valid = 1'b0;
    logic [15:0] short_addr = 16'h0000;
    logic [31:0] reg_addr = 32'h0000_0000;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic cpu_op_done = 1'b0;
    logic dma_start = 1'b0;
    logic dma_slow = 1'b0;
    logic dma_req, dma_done, dma_grant_reg, cpu_hold_reg;
    logic jump_done_reg, jump_taken_reg, irq_allowed_reg;
    flags_s flags_reg;
    logic [23:0] full_addr_reg;
    logic [7:0] reg_rdata_reg;
    logic [7:0] rd;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;

    status_flags_cond_eval u_status_flags_cond_eval (
        .sys_clk, .rstn, .exec_op, .flags_load, .exc_take, .irq_pending,
        .jump_req, .short_addr_valid, .short_addr, .reg_addr, .reg_rd,
        .reg_wr, .reg_wdata, .cpu_op_done, .dma_req, .dma_done, .flags_reg,
        .jump_done_reg, .jump_taken_reg, .irq_allowed_reg, .full_addr_reg,
        .reg_rdata_reg, .dma_grant_reg, .cpu_hold_reg
    );

    dma_partner u_dma_partner (
        .sys_clk, .rstn, .start(dma_start), .slow(dma_slow),
        .dma_grant_reg, .dma_req, .dma_done
    );

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic test_done();
        $display("Compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // Generous ceiling; the full sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end

    task automatic reg_write(logic [31:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : reg_write

    task automatic reg_read(logic [31:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        rd = reg_rdata_reg;
        reg_rd = 1'b0;
        tick(1);
    endtask : reg_read

    task automatic load_flags(logic [7:0] v);
        flags_load = '{1'b1, flags_s'(v)};
        tick(1);
        flags_load.valid = 1'b0;
        tick(1);
    endtask : load_flags

    // x packs shift carry, prior msb, blank tests and extension kind
    task automatic do_op(op_kind_e k, size_e sz, logic t, logic [4:0] x,
                         logic [4:0] e, logic [31:0] d, s, r);
        exec_op = exec_op_s'({1'b1, k, sz, t, d, s, r, x});
        tick(1);
        exec_op.valid = 1'b0;
        `CHK(flags_reg[7:3], e)
        tick(1);
    endtask : do_op

    function automatic logic exp_jump(logic [3:0] code, logic [7:0] f);
        logic t;
        case (code[2:0])
            3'h0: t = f[3];
            3'h1: t = f[5] ^ f[4];
            3'h2: t = f[6] | (f[5] ^ f[4]);
            3'h3: t = f[7] | f[6];
            3'h4: t = f[4];
            3'h5: t = f[5];
            3'h6: t = f[6];
            default: t = f[7];
        endcase
        return code[3] ? !t : t;
    endfunction : exp_jump

    task automatic test_regs();
        `CHK(flags_reg, 8'h00)
        reg_read(32'hffff_e012);
        `CHK(rd, 8'hff)
        reg_read(32'hffff_e011);
        `CHK(rd, 8'hff)
        reg_write(32'h00ff_e012, 8'h00);
        reg_read(32'h12ff_e012);
        `CHK(rd, 8'hfc)
        reg_write(32'hffff_e013, 8'h03);
        reg_read(32'hffff_e012);
        `CHK(rd, 8'hfc)
        reg_write(32'hffff_e010, 8'h5a);
        reg_read(32'h00ff_e010);
        `CHK(rd, 8'h5a)
    endtask : test_regs

    task automatic test_arith();
        load_flags(8'h04);
        do_op(OP_ADD, SZ_QUAD, 1'b1, 5'h00, 5'h06,
              32'h7fff_ffff, 32'h0000_0001, 32'h8000_0000);
        do_op(OP_ADD, SZ_BYTE, 1'b0, 5'h04, 5'h18,
              32'h0000_12ff, 32'h0000_0001, 32'h0000_1300);
        do_op(OP_ADD, SZ_WORD, 1'b1, 5'h02, 5'h00,
              32'h0000_ffff, 32'h0000_0001, 32'h0001_0000);
        do_op(OP_SUB, SZ_QUAD, 1'b1, 5'h00, 5'h02,
              32'h8000_0000, 32'h0000_0001, 32'h7fff_ffff);
        do_op(OP_LOGIC, SZ_QUAD, 1'b1, 5'h00, 5'h04,
              32'h8000_0000, 32'hffff_ffff, 32'h8000_0000);
        do_op(OP_SUB, SZ_QUAD, 1'b1, 5'h04, 5'h15,
              32'h0000_0000, 32'h0000_0001, 32'hffff_ffff);
        do_op(OP_SHIFT, SZ_QUAD, 1'b1, 5'h10, 5'h17,
              32'h4000_0000, 32'h0000_0001, 32'h8000_0000);
        do_op(OP_SHIFT, SZ_BYTE, 1'b0, 5'h18, 5'h1b,
              32'h0000_0080, 32'h0000_0001, 32'h0000_0100);
        do_op(OP_BITTEST, SZ_QUAD, 1'b1, 5'h00, 5'h13,
              32'h0000_0030, 32'h0000_0010, 32'h0000_0010);
        do_op(OP_LOAD, SZ_BYTE, 1'b0, 5'h03, 5'h12,
              32'h0000_0000, 32'h0000_0080, 32'h0000_0080);
        do_op(OP_LOAD, SZ_BYTE, 1'b0, 5'h02, 5'h13,
              32'h0000_0000, 32'h0000_ff00, 32'h0000_ff00);
        do_op(OP_POP, SZ_QUAD, 1'b1, 5'h02, 5'h12,
              32'h0000_0000, 32'h0000_0005, 32'h0000_0005);
        `CHK(flags_reg[2:0], 3'h4)
    endtask : test_arith

    task automatic test_jump();
        logic [7:0] pats [5] = '{8'h00, 8'hf8, 8'h90, 8'h68, 8'h07};
        logic e;
        foreach (pats[p]) begin
            load_flags(pats[p]);
            for (int code = 0; code < 16; code++) begin
                e = exp_jump(4'(code), pats[p]);
                jump_req = '{1'b1, 4'(code)};
                tick(1);
                jump_req.valid = 1'b0;
                `CHK({jump_done_reg, jump_taken_reg}, {1'b1, e})
                tick(1);
                `CHK(jump_done_reg, 1'b0)
            end
        end
    endtask : test_jump

    task automatic test_irq();
        irq_pending = 1'b1;
        load_flags(8'h01);
        `CHK(irq_allowed_reg, 1'b1)
        exc_take = 1'b1;
        tick(1);
        exc_take = 1'b0;
        `CHK(flags_reg.chain_enable_bit, 1'b1)
        tick(1);
        load_flags(8'h02);
        `CHK(irq_allowed_reg, 1'b0)
        exc_take = 1'b1;
        tick(1);
        exc_take = 1'b0;
        `CHK(flags_reg.chain_enable_bit, 1'b0)
        irq_pending = 1'b0;
        tick(1);
    endtask : test_irq

    task automatic test_addr();
        logic [15:0] a [2] = '{16'hfeff, 16'h7fff};
        logic [23:0] e [2] = '{24'hff_feff, 24'h00_7fff};
        foreach (a[i]) begin
            short_addr = a[i];
            short_addr_valid = 1'b1;
            tick(1);
            short_addr_valid = 1'b0;
            `CHK(full_addr_reg, e[i])
            tick(1);
        end
    endtask : test_addr

    task automatic op_pulse();
        cpu_op_done = 1'b1;
        tick(1);
        cpu_op_done = 1'b0;
        tick(1);
    endtask : op_pulse

    task automatic test_dma();
        for (int n = 0; n < 4; n++) begin
            reg_write(32'hffff_e012, 8'(n));
            dma_slow = n[0];
            dma_start = 1'b1;
            tick(1);
            dma_start = 1'b0;
            for (int i = 1; i < n; i++) op_pulse();
            tick(2);
            if (n == 0) begin
                `CHK({dma_grant_reg, cpu_hold_reg}, 2'b11)
            end else begin
                `CHK(dma_grant_reg, 1'b0)
                op_pulse();
                `CHK({dma_grant_reg, cpu_hold_reg}, 2'b10)
            end
            for (int i = 0; i < 10 && dma_req; i++) tick(1);
            tick(1);
            `CHK(dma_grant_reg, 1'b0)
        end
    endtask : test_dma

    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        tick(1);
        test_regs();
        test_arith();
        test_jump();
        test_irq();
        test_addr();
        test_dma();
        test_done();
    end
endmodule : tb_status_flags_cond_eval
